/* design/lcd_iu.sv */
// Function
// RL1 - Eight-bit mode: one strobe per byte
// RL2 - Four-bit mode: lines 7:4, upper nibble first
// RL3 - Busy rises only after second nibble
// RL4 - While busy, new instructions are ignored
// RL5 - Status read: busy on bit7, pointer below
// RL6 - Host polls busy before each instruction
// RL7 - Pointer loaded by address set, steps by one
// RL8 - Rows map to 00-0F and 40-4F
// RL9 - Code bits 2:0 give glyph address 5:3
// RL10 - Glyph address bits 2:0 select row
// RL11 - Eighth row ORed with the cursor; code lights it only for user glyphs (code bits 7:4 zero)
// RL12 - Row pixels from data bits 4:0
// RL13 - User glyph when code bits 7:4 zero
// RL14 - Clear: fill spaces, pointer zero, long time
// RL15 - Home: pointer zero, unshift, long time
// RL16 - Entry mode latches direction and shift
// RL17 - Display control latches three bits
// RL18 - Shift picks cursor/display and direction
// RL19 - Function set latches width, lines, font
// RL20 - Glyph or display address into pointer
// RL21 - Data write/read on selected RAM
// RL22 - Host waits half oscillator after busy drops
// RL23 - Direction sets pointer step; shift on writes
// RL24 - Shift codes move cursor or display
// RL25 - Width, line and font bit meanings
// RL26 - Display, cursor and blink enables
// RL27 - Capture on enable fall; drive while high

`include "lcd_iu_params.svh"

// ******************************
// Command buffer
// ******************************
module lcd_iu_fifo #(
  parameter int W = 10,
  parameter int D = 32
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } fifo_st_s;
  fifo_st_s st_reg;
  fifo_st_s st_next;
  logic [W-1:0] mem [D];
  logic push;
  logic pop;

  assign in_ready = (st_reg.wp ^ st_reg.rp) != {1'b1, {AW{1'b0}}};
  assign out_valid = st_reg.wp != st_reg.rp;
  assign out_data = mem[st_reg.rp[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.wp = st_reg.wp + 1'b1;
    end
    if (pop) begin
      st_next.rp = st_reg.rp + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[st_reg.wp[AW-1:0]] <= in_data;
    end
  end
endmodule

// ******************************
// Instruction unit
// ******************************
module lcd_iu #(
  parameter logic [`CNT_W-1:0] LONG_CYCLES = `CNT_W'(`CYC(`T_LONG_NS)),
  parameter logic [`BLINK_W-1:0] BLINK_CYCLES = `BLINK_W'(`BLINK_DEF)
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire lcd_iu_pkg::host_in_s host_in,
  output lcd_iu_pkg::host_out_s host_out,
  output logic busy_indicator,
  output lcd_iu_pkg::mode_s mode,
  input wire logic [`PTR_W-1:0] scan_addr,
  output logic [`DB_W-1:0] scan_char,
  input wire lcd_iu_pkg::glyph_req_s glyph_req,
  output logic glyph_user,
  output logic [`PIX_W-1:0] glyph_pix,
  output logic cursor_lit
);
  import lcd_iu_pkg::*;

  localparam logic [`CNT_W-1:0] SHORT_CYC = `CNT_W'(`CYC(`T_SHORT_NS));
  localparam logic [`CNT_W-1:0] DATA_CYC = `CNT_W'(`CYC(`T_DATA_NS));

  typedef struct packed {
    logic en_prev;
    logic phase;
    logic [`NIB_W-1:0] hi_nib;
    logic [`DB_W-1:0] rd_full;
    logic [`DB_W-1:0] db_out;
    logic inc;
    logic sh;
    mode_s mode;
    logic ram_cg;
    logic [`PTR_W-1:0] ptr;
    logic [`DB_W-1:0] data_hold;
    exec_e xs;
    logic [`CNT_W-1:0] cnt;
    logic [`PTR_W-1:0] cl_idx;
    logic [`BLINK_W-1:0] blink_cnt;
    logic blink_ph;
    logic user;
    logic [`PIX_W-1:0] pix;
    logic [`DB_W-1:0] scan_char;
  } core_s;

  core_s st_reg;
  core_s st_next;
  logic [`DB_W-1:0] dd_ram [`DD_DEPTH];
  logic [`DB_W-1:0] cg_ram [`CG_DEPTH];
  logic dd_we;
  logic cg_we;
  logic [`PTR_W-1:0] dd_wa;
  logic [`CG_AW-1:0] cg_wa;
  logic [`DB_W-1:0] ram_wd;
  cmd_s push_cmd;
  logic push_valid;
  logic push_ready;
  cmd_s pop_cmd;
  logic pop_valid;
  logic pop_ready;

  function automatic op_e decode(input logic [`DB_W-1:0] v);
    if (v[7]) begin
      return OP_SET_DD;
    end else if (v[6]) begin
      return OP_SET_CG;
    end else if (v[5]) begin
      return OP_FUNC;
    end else if (v[4]) begin
      return OP_SHIFT;
    end else if (v[3]) begin
      return OP_DISP;
    end else if (v[2]) begin
      return OP_ENTRY;
    end else if (v[1]) begin
      return OP_HOME;
    end else if (v[0]) begin
      return OP_CLEAR;
    end
    return OP_NONE;
  endfunction

  function automatic logic [`PTR_W-1:0] step(input logic [`PTR_W-1:0] p, input logic up,
                                             input logic cg);
    logic [`PTR_W-1:0] r;
    r = up ? p + 7'h01 : p - 7'h01;
    if (cg) begin
      r[`PTR_W-1] = 1'b0;
    end
    return r;
  endfunction

  function automatic logic [`DB_W-1:0] ram_rd(input logic [`PTR_W-1:0] p, input logic cg);
    return cg ? cg_ram[p[`CG_AW-1:0]] : dd_ram[p];
  endfunction

  lcd_iu_fifo #(
    .W($bits(cmd_s)),
    .D(`FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_data(push_cmd),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .out_data(pop_cmd),
    .out_valid(pop_valid),
    .out_ready(pop_ready)
  );

  // Busy covers queued, executing and stalled work
  assign busy_indicator = pop_valid || (st_reg.xs != XS_IDLE) || !push_ready;
  assign pop_ready = st_reg.xs == XS_IDLE;
  assign host_out.oe = host_in.en && host_in.rw; // RL27
  assign host_out.db = st_reg.db_out;
  assign mode = st_reg.mode;
  assign scan_char = st_reg.scan_char;
  assign glyph_user = st_reg.user;
  assign glyph_pix = st_reg.pix;
  assign cursor_lit = st_reg.mode.cur_on && (!st_reg.mode.blink_on || st_reg.blink_ph); // RL26

  always_comb begin
    logic en_rise;
    logic en_fall;
    logic byte_done;
    logic [`DB_W-1:0] byte_v;
    logic [`DB_W-1:0] rd_v;
    logic [`ROW_W-1:0] rrow;
    logic [`CG_AW-1:0] gaddr;
    op_e op;
    en_rise = host_in.en && !st_reg.en_prev;
    en_fall = !host_in.en && st_reg.en_prev;
    byte_done = 1'b0;
    byte_v = host_in.db;
    rd_v = '0;
    rrow = '0;
    gaddr = '0;
    op = OP_NONE;
    st_next = st_reg;
    push_cmd = '0;
    push_valid = 1'b0;
    dd_we = 1'b0;
    cg_we = 1'b0;
    dd_wa = '0;
    cg_wa = '0;
    ram_wd = '0;
    st_next.en_prev = host_in.en;

    // ******************************
    // Host strobes
    // ******************************
    if (en_rise && host_in.rw) begin
      rd_v = host_in.rs ? st_reg.data_hold : {busy_indicator, st_reg.ptr}; // RL5
      if (st_reg.mode.bus8) begin
        st_next.db_out = rd_v; // RL1
      end else if (!st_reg.phase) begin
        st_next.rd_full = rd_v;
        st_next.db_out = {rd_v[7:4], 4'h0}; // RL2
      end else begin
        st_next.db_out = {st_reg.rd_full[3:0], 4'h0}; // RL2
      end
    end
    if (en_fall) begin // RL27
      if (st_reg.mode.bus8) begin
        byte_done = 1'b1; // RL1
      end else if (!st_reg.phase) begin
        st_next.phase = 1'b1;
        st_next.hi_nib = host_in.db[7:4]; // RL2
      end else begin
        st_next.phase = 1'b0;
        byte_done = 1'b1; // RL3
        byte_v = {st_reg.hi_nib, host_in.db[7:4]}; // RL2
      end
    end
    // Status reads are free; everything else queues while idle
    if (byte_done && !busy_indicator && (host_in.rs || !host_in.rw)) begin // RL4
      push_cmd.is_data = host_in.rs;
      push_cmd.is_read = host_in.rw;
      push_cmd.val = byte_v;
      push_valid = 1'b1;
    end

    // ******************************
    // Execution
    // ******************************
    case (st_reg.xs)
      XS_IDLE: begin
        if (pop_valid) begin
          st_next.xs = XS_RUN;
          st_next.cnt = SHORT_CYC;
          if (pop_cmd.is_data) begin
            st_next.cnt = DATA_CYC; // RL21
            st_next.ptr = step(st_reg.ptr, st_reg.inc, st_reg.ram_cg); // RL7 RL23
            if (pop_cmd.is_read) begin
              st_next.data_hold = ram_rd(st_next.ptr, st_reg.ram_cg); // RL21
            end else if (st_reg.ram_cg) begin
              cg_we = 1'b1;
              cg_wa = st_reg.ptr[`CG_AW-1:0];
              ram_wd = pop_cmd.val; // RL21
            end else begin
              dd_we = 1'b1;
              dd_wa = st_reg.ptr;
              ram_wd = pop_cmd.val; // RL21
              if (st_reg.sh) begin
                st_next.mode.shift_pos = step(st_reg.mode.shift_pos, !st_reg.inc, 1'b0); // RL23
              end
            end
          end else begin
            op = decode(pop_cmd.val);
            case (op)
              OP_CLEAR: begin
                st_next.xs = XS_CLR;
                st_next.cnt = LONG_CYCLES;
                st_next.cl_idx = '0;
                st_next.ptr = '0;
                st_next.ram_cg = 1'b0;
                st_next.inc = `RST_INC; // RL14
              end
              OP_HOME: begin
                st_next.cnt = LONG_CYCLES;
                st_next.ptr = '0;
                st_next.ram_cg = 1'b0;
                st_next.mode.shift_pos = '0; // RL15
              end
              OP_ENTRY: begin
                st_next.inc = pop_cmd.val[`B_DIR];
                st_next.sh = pop_cmd.val[`B_SH]; // RL16
              end
              OP_DISP: begin
                st_next.mode.disp_on = pop_cmd.val[`B_DON];
                st_next.mode.cur_on = pop_cmd.val[`B_CON];
                st_next.mode.blink_on = pop_cmd.val[`B_BLK]; // RL17
              end
              OP_SHIFT: begin
                if (pop_cmd.val[`B_SC]) begin
                  st_next.mode.shift_pos = step(st_reg.mode.shift_pos, pop_cmd.val[`B_RL], 1'b0); // RL24
                end else begin
                  st_next.ptr = step(st_reg.ptr, pop_cmd.val[`B_RL], st_reg.ram_cg); // RL18
                  st_next.data_hold = ram_rd(st_next.ptr, st_reg.ram_cg);
                end
              end
              OP_FUNC: begin
                st_next.mode.bus8 = pop_cmd.val[`B_DL];
                st_next.mode.two_line = pop_cmd.val[`B_N];
                st_next.mode.tall_font = pop_cmd.val[`B_F]; // RL19 RL25
                st_next.phase = 1'b0;
              end
              OP_SET_CG: begin
                st_next.ram_cg = 1'b1;
                st_next.ptr = {1'b0, pop_cmd.val[`CG_AW-1:0]}; // RL20
                st_next.data_hold = ram_rd(st_next.ptr, 1'b1);
              end
              OP_SET_DD: begin
                st_next.ram_cg = 1'b0;
                st_next.ptr = pop_cmd.val[`PTR_W-1:0]; // RL20 RL8
                st_next.data_hold = ram_rd(st_next.ptr, 1'b0);
              end
              default: begin
                st_next.cnt = SHORT_CYC;
              end
            endcase
          end
        end
      end
      XS_RUN: begin
        st_next.cnt = st_reg.cnt - 1'b1;
        if (st_reg.cnt <= `CNT_W'(1)) begin
          st_next.xs = XS_IDLE;
        end
      end
      XS_CLR: begin
        dd_we = 1'b1;
        dd_wa = st_reg.cl_idx;
        ram_wd = `SPACE_CODE; // RL14
        st_next.cl_idx = st_reg.cl_idx + 1'b1;
        st_next.cnt = st_reg.cnt - 1'b1;
        if (st_reg.cnt <= `CNT_W'(1)) begin
          st_next.xs = XS_IDLE;
        end
      end
      default: begin
        st_next.xs = XS_IDLE;
      end
    endcase

    // ******************************
    // Display side
    // ******************************
    if (st_reg.blink_cnt >= BLINK_CYCLES - 1'b1) begin
      st_next.blink_cnt = '0;
      st_next.blink_ph = !st_reg.blink_ph; // RL26
    end else begin
      st_next.blink_cnt = st_reg.blink_cnt + 1'b1;
    end
    st_next.scan_char = dd_ram[scan_addr]; // RL8
    rrow = glyph_req.row;
    gaddr = {glyph_req.code[2:0], rrow}; // RL9 RL10 RL13
    st_next.user = glyph_req.code[7:4] == `USER_HI; // RL13
    st_next.pix = cg_ram[gaddr][`PIX_W-1:0]; // RL12
    if (rrow == `ROW_CURSOR && glyph_req.cursor_here && cursor_lit) begin
      st_next.pix = {`PIX_W{1'b1}}; // RL11
    end
    if (!st_reg.mode.disp_on || !st_next.user) begin
      st_next.pix = '0; // RL26
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= '0;
      st_reg.xs <= XS_IDLE;
      st_reg.inc <= `RST_INC;
      st_reg.mode.bus8 <= `RST_BUS8;
    end else begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge clk) begin
    if (dd_we) begin
      dd_ram[dd_wa] <= ram_wd;
    end
    if (cg_we) begin
      cg_ram[cg_wa] <= ram_wd;
    end
  end
endmodule

/* design/lcd_iu_params.svh */
`ifndef LCD_IU_PARAMS_SVH
`define LCD_IU_PARAMS_SVH
// ******************************
// Widths and depths
// ******************************
`define DB_W 8
`define NIB_W 4
`define PTR_W 7
`define CG_AW 6
`define DD_DEPTH 128
`define CG_DEPTH 64
`define FIFO_DEPTH 32
`define CNT_W 17
`define BLINK_W 24
`define PIX_W 5
`define ROW_W 3
// ******************************
// Timing
// ******************************
`define CLK_NS 25
`define T_LONG_NS 1530000
`define T_SHORT_NS 39000
`define T_DATA_NS 43000
`define CYC(ns) (((ns) + `CLK_NS - 1) / `CLK_NS)
`define BLINK_DEF 16000000
// ******************************
// Instruction fields and values
// ******************************
`define B_DIR 1
`define B_SH 0
`define B_DON 2
`define B_CON 1
`define B_BLK 0
`define B_SC 3
`define B_RL 2
`define B_DL 4
`define B_N 3
`define B_F 2
`define SPACE_CODE 8'h20
`define ROW_CURSOR 3'h7
`define USER_HI 4'h0
`define RST_BUS8 1'b1
`define RST_INC 1'b1
`endif

/* design/lcd_iu_pkg.sv */
`include "lcd_iu_params.svh"
package lcd_iu_pkg;
  typedef struct packed {
    logic rs;
    logic rw;
    logic en;
    logic [`DB_W-1:0] db;
  } host_in_s;

  typedef struct packed {
    logic oe;
    logic [`DB_W-1:0] db;
  } host_out_s;

  typedef struct packed {
    logic is_data;
    logic is_read;
    logic [`DB_W-1:0] val;
  } cmd_s;

  typedef struct packed {
    logic disp_on;
    logic cur_on;
    logic blink_on;
    logic two_line;
    logic tall_font;
    logic bus8;
    logic [`PTR_W-1:0] shift_pos;
  } mode_s;

  typedef struct packed {
    logic [`DB_W-1:0] code;
    logic [`ROW_W-1:0] row;
    logic cursor_here;
  } glyph_req_s;

  typedef enum logic [2:0] {
    XS_IDLE = 3'h1,
    XS_RUN = 3'h2,
    XS_CLR = 3'h4
  } exec_e;

  typedef enum logic [3:0] {
    OP_NONE, OP_CLEAR, OP_HOME, OP_ENTRY, OP_DISP, OP_SHIFT, OP_FUNC, OP_SET_CG, OP_SET_DD
  } op_e;
endpackage

/* verif/lcd_iu_assertions.sv */
`include "lcd_iu_params.svh"
module lcd_iu_checker #(
  parameter logic [`CNT_W-1:0] LONG_CYCLES = `CNT_W'(`CYC(`T_LONG_NS)),
  parameter logic [`BLINK_W-1:0] BLINK_CYCLES = `BLINK_W'(`BLINK_DEF)
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire lcd_iu_pkg::host_in_s host_in,
  input wire lcd_iu_pkg::host_out_s host_out,
  input wire logic busy_indicator,
  input wire lcd_iu_pkg::mode_s mode,
  input wire lcd_iu_pkg::glyph_req_s glyph_req,
  input wire logic glyph_user,
  input wire logic [`PIX_W-1:0] glyph_pix,
  input wire logic cursor_lit
);
  timeunit 1ns;
  timeprecision 1ps;
  import lcd_iu_pkg::*;
  localparam logic [`CNT_W-1:0] T_INS = `CNT_W'(`CYC(`T_SHORT_NS) + 1);
  localparam logic [`CNT_W-1:0] T_DAT = `CNT_W'(`CYC(`T_DATA_NS) + 1);
  logic [`CNT_W-1:0] run_reg;
  logic [1:0] fall_age_reg;
  logic en_reg;
  // ******************************
  // Busy run length and strobe age
  // ******************************
  always_ff @(posedge clk) begin
    en_reg <= host_in.en;
    if (sys_rst) begin
      run_reg <= '0;
      fall_age_reg <= 2'h3;
    end else begin
      run_reg <= busy_indicator ? run_reg + 1'b1 : '0;
      fall_age_reg <= (en_reg && !host_in.en) ? 2'h0 : (fall_age_reg == 2'h3 ? 2'h3 : fall_age_reg + 1'b1);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_stat_rd;
    ($rose(host_in.en) && !host_in.rs && host_in.rw && mode.bus8) ##1 (host_in.en && $stable(busy_indicator))[*2];
  endsequence
  sequence s_cur_row;
    glyph_req.cursor_here && glyph_req.row == `ROW_CURSOR && glyph_req.code[7:4] == `USER_HI &&
      cursor_lit && mode.disp_on;
  endsequence
  a_oe_follows_en: assert property (host_out.oe == (host_in.en && host_in.rw))
    else $error("data drive does not follow enable and read");
  a_busy_after_fall: assert property ($rose(busy_indicator) |-> fall_age_reg <= 2'h2)
    else $error("busy rose without a strobe fall");
  a_busy_length: assert property ($fell(busy_indicator) |->
    run_reg == T_INS || run_reg == T_DAT || run_reg == LONG_CYCLES + 1'b1)
    else $error("busy run length wrong");
  a_status_bit7: assert property (s_stat_rd |-> host_out.db[7] == busy_indicator)
    else $error("status bit 7 differs from busy");
  a_nibble_low: assert property ($rose(host_in.en) && host_in.rw && !mode.bus8 |-> ##2 host_out.db[3:0] == 4'h0)
    else $error("low lines not zero in nibble read");
  a_user_select: assert property (!$past(sys_rst) |-> glyph_user == ($past(glyph_req.code[7:4]) == `USER_HI))
    else $error("user glyph select wrong");
  a_other_dark: assert property (!glyph_user |-> glyph_pix == 5'h00)
    else $error("pixels lit for non-user code");
  a_cursor_or: assert property (s_cur_row |=> glyph_pix == 5'h1f)
    else $error("cursor row not lit");
  a_display_off: assert property (!mode.disp_on |=> glyph_pix == 5'h00)
    else $error("pixels lit with display off");
  a_cursor_hidden: assert property (!mode.cur_on |-> !cursor_lit)
    else $error("cursor lit while hidden");
endmodule

/* verif/lcd_host_model.sv */
module lcd_host_model #(
  parameter int HALF_OSC = 75
) (
  input wire logic clk,
  input wire logic busy_indicator,
  input wire lcd_iu_pkg::host_out_s host_out,
  output lcd_iu_pkg::host_in_s host_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import lcd_iu_pkg::*;
  int busy_cnt = 0;
  initial host_in = '0;
  always @(posedge clk) if (busy_indicator === 1'b1) busy_cnt++;
  // Lines held through the enable fall, released lines inverted
  task automatic strobe(input logic rs, input logic rw, input logic [7:0] b, output logic [7:0] r);
    @(posedge clk);
    host_in.rs <= rs;
    host_in.rw <= rw;
    host_in.db <= rw ? ~host_in.db : b;
    host_in.en <= 1'b1;
    repeat (3) @(posedge clk);
    r = host_out.db;
    host_in.en <= 1'b0;
    repeat (2) @(posedge clk);
    host_in.db <= ~host_in.db;
  endtask
  task automatic xfer(input logic rs, input logic rw, input logic [7:0] b, input logic four, output logic [7:0] r);
    logic [7:0] hi;
    logic [7:0] lo;
    if (four) begin
      strobe(rs, rw, {b[7:4], 4'h0}, hi);
      strobe(rs, rw, {b[3:0], 4'h0}, lo);
      r = {hi[7:4], lo[7:4]};
    end else begin
      strobe(rs, rw, b, r);
    end
  endtask
  task automatic settle();
    int n;
    n = 0;
    while (busy_indicator === 1'b1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    repeat (HALF_OSC) @(posedge clk);
  endtask
endmodule

/* verif/tb.sv */
`include "lcd_iu_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lcd_iu_pkg::*;
  localparam logic [`CNT_W-1:0] LONG = `CNT_W'(200);
  localparam int T_INS = `CYC(`T_SHORT_NS) + 1;
  localparam int T_DAT = `CYC(`T_DATA_NS) + 1;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  host_in_s host_in;
  host_out_s host_out;
  logic busy_indicator;
  mode_s mode;
  logic [`PTR_W-1:0] scan_addr = '0;
  logic [`DB_W-1:0] scan_char;
  glyph_req_s glyph_req = '0;
  logic glyph_user;
  logic [`PIX_W-1:0] glyph_pix;
  logic cursor_lit;
  logic four = 1'b0;
  logic [7:0] r;
  int c0;
  int n_mismatch = 0;
  int comparisons = 0;
  logic [13:0] rows [8] = '{{8'h0c, 6'h21}, {8'h0f, 6'h39}, {8'h38, 6'h3d}, {8'h3c, 6'h3f},
    {8'h08, 6'h07}, {8'h0e, 6'h37}, {8'h34, 6'h33}, {8'h38, 6'h35}};
  always #12.5 clk = ~clk;
  lcd_iu #(.LONG_CYCLES(LONG), .BLINK_CYCLES(`BLINK_W'(8))) lcd_iu_i (.clk(clk), .sys_rst(sys_rst),
    .host_in(host_in), .host_out(host_out), .busy_indicator(busy_indicator), .mode(mode),
    .scan_addr(scan_addr), .scan_char(scan_char), .glyph_req(glyph_req), .glyph_user(glyph_user),
    .glyph_pix(glyph_pix), .cursor_lit(cursor_lit));
  lcd_host_model lcd_host_model_i (.clk(clk), .busy_indicator(busy_indicator), .host_out(host_out),
    .host_in(host_in));
  // ******************************
  // Checks and bus helpers
  // ******************************
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_len(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic op(input logic rs, input logic rw, input logic [7:0] b, input int len);
    c0 = lcd_host_model_i.busy_cnt;
    lcd_host_model_i.xfer(rs, rw, b, four, r);
    lcd_host_model_i.settle();
    cmp_len(lcd_host_model_i.busy_cnt - c0, len);
  endtask
  task automatic stat(input logic [7:0] exp);
    lcd_host_model_i.xfer(1'b0, 1'b1, 8'h00, four, r);
    cmp(r, exp);
  endtask
  task automatic scan_chk(input logic [6:0] a, input logic [7:0] exp);
    @(posedge clk);
    scan_addr <= a;
    repeat (3) @(posedge clk);
    cmp(scan_char, exp);
  endtask
  task automatic gchk(input glyph_req_s g, input logic u, input logic [4:0] p);
    @(posedge clk);
    glyph_req <= g;
    repeat (3) @(posedge clk);
    cmp({7'h0, glyph_user}, {7'h0, u});
    cmp({3'h0, glyph_pix}, {3'h0, p});
  endtask
  task automatic end_of_test();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #2500000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    cmp({2'h0, mode[12:7]}, 8'h01);
    stat(8'h00);
    for (int i = 0; i < 8; i++) begin
      op(1'b0, 1'b0, rows[i][13:6], T_INS);
      cmp({2'h0, mode[12:7]}, {2'h0, rows[i][5:0]});
    end
    op(1'b0, 1'b0, 8'h01, LONG + 1);
    stat(8'h00);
    scan_chk(7'h45, 8'h20);
    op(1'b0, 1'b0, 8'hc0, T_INS);
    stat(8'h40);
    op(1'b1, 1'b0, 8'h41, T_DAT);
    stat(8'h41);
    scan_chk(7'h40, 8'h41);
    op(1'b0, 1'b0, 8'h04, T_INS);
    op(1'b1, 1'b0, 8'h42, T_DAT);
    stat(8'h40);
    op(1'b0, 1'b0, 8'h14, T_INS);
    stat(8'h41);
    op(1'b0, 1'b0, 8'h1c, T_INS);
    stat(8'h41);
    cmp({1'b0, mode[6:0]}, 8'h01);
    op(1'b0, 1'b0, 8'h03, LONG + 1);
    stat(8'h00);
    cmp({1'b0, mode[6:0]}, 8'h00);
    op(1'b0, 1'b0, 8'h07, T_INS);
    op(1'b0, 1'b0, 8'hc0, T_INS);
    op(1'b1, 1'b1, 8'h00, T_DAT);
    cmp(r, 8'h41);
    stat(8'h41);
    op(1'b0, 1'b0, 8'h48, T_INS);
    op(1'b1, 1'b0, 8'h15, T_DAT);
    op(1'b1, 1'b0, 8'h0a, T_DAT);
    op(1'b0, 1'b0, 8'h4f, T_INS);
    op(1'b1, 1'b0, 8'h00, T_DAT);
    cmp({1'b0, mode[6:0]}, 8'h00);
    gchk({8'h09, 3'h0, 1'b0}, 1'b1, 5'h15);
    gchk({8'h01, 3'h1, 1'b0}, 1'b1, 5'h0a);
    gchk({8'h01, 3'h7, 1'b1}, 1'b1, 5'h1f);
    gchk({8'h11, 3'h0, 1'b0}, 1'b0, 5'h00);
    op(1'b0, 1'b0, 8'h80, T_INS);
    op(1'b1, 1'b0, 8'h20, T_DAT);
    cmp({1'b0, mode[6:0]}, 8'h7f);
    c0 = lcd_host_model_i.busy_cnt;
    lcd_host_model_i.xfer(1'b0, 1'b0, 8'h0e, four, r);
    lcd_host_model_i.xfer(1'b0, 1'b0, 8'h08, four, r);
    lcd_host_model_i.settle();
    cmp_len(lcd_host_model_i.busy_cnt - c0, T_INS);
    cmp({7'h0, mode.disp_on}, 8'h01);
    op(1'b0, 1'b0, 8'h28, T_INS);
    cmp({7'h0, mode.bus8}, 8'h00);
    c0 = lcd_host_model_i.busy_cnt;
    lcd_host_model_i.strobe(1'b0, 1'b0, 8'h00, r);
    cmp({7'h0, busy_indicator}, 8'h00);
    lcd_host_model_i.strobe(1'b0, 1'b0, 8'h80, r);
    lcd_host_model_i.settle();
    cmp_len(lcd_host_model_i.busy_cnt - c0, T_INS);
    cmp({7'h0, mode.disp_on}, 8'h00);
    four = 1'b1;
    stat(8'h01);
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    four = 1'b0;
    @(posedge clk);
    cmp({2'h0, mode[12:7]}, 8'h01);
    stat(8'h00);
    end_of_test();
  end
endmodule
bind lcd_iu lcd_iu_checker #(.LONG_CYCLES(LONG_CYCLES), .BLINK_CYCLES(BLINK_CYCLES)) lcd_iu_checker_i (
  .clk(clk), .sys_rst(sys_rst), .host_in(host_in), .host_out(host_out), .busy_indicator(busy_indicator),
  .mode(mode), .glyph_req(glyph_req), .glyph_user(glyph_user), .glyph_pix(glyph_pix), .cursor_lit(cursor_lit));
